/* ebt_pkg.sv */
package ebt_pkg;

  // Register byte addresses
  localparam logic [3:0] EBT_OFF_OPTION  = 4'h0;
  localparam logic [3:0] EBT_OFF_INTCTL  = 4'h4;
  localparam logic [3:0] EBT_OFF_COUNT   = 4'h8;
  localparam logic [3:0] EBT_OFF_STATUS  = 4'hC;
  localparam logic [3:0] EBT_OFF_ENABLE  = 4'h0; // Word index 4 below
  localparam logic [5:0] EBT_ADDR_ENABLE = 6'h10;
  localparam logic [5:0] EBT_ADDR_CLEAR  = 6'h14;

  // Option register field positions
  localparam int EBT_POS_SRC    = 5;
  localparam int EBT_POS_EDGE   = 4;
  localparam int EBT_POS_ASSIGN = 3;

  // Interrupt control field positions
  localparam int EBT_POS_IRQ_EN = 5;
  localparam int EBT_POS_OVF    = 2;

  // Status, enable and clear share this layout
  localparam int EBT_POS_EVT_OVF = 0;

  // Reset values
  localparam logic [7:0] EBT_RST_OPTION = 8'hFF;
  localparam logic [7:0] EBT_RST_COUNT  = 8'h00;

  // Timing counts, in instruction cycles and clk phases
  localparam logic [1:0] EBT_PHASES_LAST = 2'h3;
  localparam logic [1:0] EBT_PHASE_Q2    = 2'h1;
  localparam logic [1:0] EBT_PHASE_Q4    = 2'h3;
  localparam logic [1:0] EBT_WR_INHIBIT  = 2'h2;

  typedef struct packed {
    logic       pullup_disable;
    logic       int_edge;
    logic       count_source_select;
    logic       count_edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_rate_field;
  } ebt_option_t;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ebt_avs_req_t;

  typedef enum logic [1:0] {
    EBT_RD_IDLE = 2'b01,
    EBT_RD_DONE = 2'b10
  } ebt_rd_state_t;

endpackage

/* ebt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ebt_timer (
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               ce,
  // Avalon-MM slave
  input  wire ebt_pkg::ebt_avs_req_t avs_req,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // External count pin and core status
  input  wire logic               external_count_pin,
  input  wire logic               sleep_mode,
  // Watchdog side
  input  wire logic               wdt_base_tick,
  input  wire logic               watchdog_clear_instruction,
  output logic                    wdt_scaled_tick,
  // Events
  output logic                    overflow_pulse,
  output logic                    irq
);
  import ebt_pkg::*;

  ebt_option_t   option_ff;
  logic [7:0]    count_ff;
  logic [7:0]    presc_ff;
  logic          overflow_flag_ff;
  logic          overflow_irq_enable_ff;
  logic [1:0]    phase_ff;
  logic [1:0]    inhibit_ff;
  logic          pend_ff;
  logic          pin_s1_ff;
  logic          pin_s2_ff;
  logic          pin_s3_ff;
  logic          pin_lvl_ff;
  ebt_rd_state_t rd_state_ff;
  logic [31:0]   rdata_ff;
  logic          wdt_tick_ff;
  logic          ovf_pulse_ff;

  logic        instr_tick;
  logic        sample_phase;
  logic        pin_edge;
  logic        src_evt;
  logic        presc_in;
  logic        presc_out;
  logic        timer_evt;
  logic        count_inc;
  logic        rollover;
  logic        wr_ok;
  logic        rd_take;
  logic        wr_option;
  logic        wr_intctl;
  logic        wr_count;
  logic        wr_enable;
  logic        wr_clear;
  logic [7:0]  wbyte;
  logic [7:0]  nxt_presc;
  logic [31:0] nxt_rdata;

  // Mask of prescaler bits that must all be set for one output tick
  function automatic logic [7:0] presc_mask(input logic [2:0] code,
                                            input logic       to_wdt);
    logic [8:0] full;
    // Four-bit shift amount so that code 111 plus one does not wrap to zero
    full = 9'h001 << ({1'b0, code} + (to_wdt ? 4'h0 : 4'h1));
    presc_mask = 8'(full - 9'h001);
  endfunction

  // Bus decode; writes complete with no wait state
  assign wbyte     = avs_req.writedata[7:0];
  assign wr_ok     = ce & avs_req.write & avs_req.byteenable[0];
  assign wr_option = wr_ok & (avs_req.address == {2'h0, EBT_OFF_OPTION});
  assign wr_intctl = wr_ok & (avs_req.address == {2'h0, EBT_OFF_INTCTL});
  assign wr_count  = wr_ok & (avs_req.address == {2'h0, EBT_OFF_COUNT});
  assign wr_enable = wr_ok & (avs_req.address == EBT_ADDR_ENABLE);
  assign wr_clear  = wr_ok & (avs_req.address == EBT_ADDR_CLEAR);
  assign rd_take   = ce & avs_req.read & (rd_state_ff == EBT_RD_IDLE);
  // Reads take one wait state so the data come from flops
  assign avs_waitrequest = ~ce | (avs_req.read & (rd_state_ff == EBT_RD_IDLE));
  assign avs_readdata    = rdata_ff;

  // Instruction-cycle phases derived from clk
  assign instr_tick   = (phase_ff == EBT_PHASES_LAST);
  assign sample_phase = (phase_ff == EBT_PHASE_Q2) |
                        (phase_ff == EBT_PHASE_Q4);

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_ff <= 2'h0;
    end else if (ce) begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_ff  <= 1'b0;
      pin_s2_ff  <= 1'b0;
      pin_s3_ff  <= 1'b0;
      pin_lvl_ff <= 1'b0;
    end else if (ce) begin
      pin_s1_ff <= external_count_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      if (pin_s2_ff == pin_s3_ff) begin
        pin_lvl_ff <= pin_s3_ff;
      end
    end
  end

  assign pin_edge = (pin_s2_ff == pin_s3_ff) & (pin_s3_ff != pin_lvl_ff) &
                    (pin_s3_ff ^ option_ff.count_edge_select);

  // Source choice and prescaler routing
  assign src_evt = option_ff.count_source_select ? pin_edge
                                                 : instr_tick;
  assign presc_in = option_ff.prescaler_assign ? wdt_base_tick
                                               : src_evt;
  assign presc_out = presc_in &
    ((presc_ff & presc_mask(option_ff.prescale_rate_field,
                            option_ff.prescaler_assign)) ==
      presc_mask(option_ff.prescale_rate_field,
                 option_ff.prescaler_assign));
  assign timer_evt = option_ff.prescaler_assign ? src_evt
                                                : presc_out;

  always_comb begin
    nxt_presc = presc_ff;
    if (presc_in) begin
      nxt_presc = presc_ff + 8'h01;
    end
    if (wr_count & ~option_ff.prescaler_assign) begin
      nxt_presc = 8'h00;
    end
    if (watchdog_clear_instruction & option_ff.prescaler_assign) begin
      nxt_presc = 8'h00;
    end
    // Reassignment restarts the shared count, except in sleep with the timer assigned, where the hold below wins
    if (wr_option & (wbyte[EBT_POS_ASSIGN] != option_ff.prescaler_assign)) begin
      nxt_presc = 8'h00;
    end
    // Timer half of the prescaler stops in sleep; watchdog half keeps going
    if (sleep_mode & ~option_ff.prescaler_assign) begin
      nxt_presc = presc_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      presc_ff <= 8'h00;
    end else if (ce) begin
      presc_ff <= nxt_presc;
    end
  end

  // Watchdog ratio output
  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_tick_ff <= 1'b0;
    end else if (ce) begin
      wdt_tick_ff <= option_ff.prescaler_assign ? presc_out
                                                : wdt_base_tick;
    end
  end
  assign wdt_scaled_tick = wdt_tick_ff;

  // Counter mode: prescaled edges wait for the next Q2 or Q4 sample
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_ff <= 1'b0;
    end else if (ce) begin
      if (wr_count | ~option_ff.count_source_select) begin
        pend_ff <= 1'b0;
      end else if (timer_evt & ~sleep_mode) begin
        pend_ff <= 1'b1;
      end else if (sample_phase & ~sleep_mode) begin
        pend_ff <= 1'b0;
      end
    end
  end

  assign count_inc = ~sleep_mode & (inhibit_ff == 2'h0) &
    (option_ff.count_source_select ? (pend_ff & sample_phase)
                                   : timer_evt);
  assign rollover = count_inc & (count_ff == 8'hFF) & ~wr_count;

  // Write hold-off counted in instruction cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      inhibit_ff <= 2'h0;
    end else if (ce) begin
      if (wr_count) begin
        inhibit_ff <= EBT_WR_INHIBIT;
      end else if (instr_tick & (inhibit_ff != 2'h0)) begin
        inhibit_ff <= inhibit_ff - 2'h1;
      end
    end
  end

  // Count register; a software write beats a same-cycle increment
  always_ff @(posedge clk) begin
    if (srst) begin
      count_ff <= EBT_RST_COUNT;
    end else if (ce) begin
      if (wr_count) begin
        count_ff <= wbyte;
      end else if (count_inc) begin
        count_ff <= count_ff + 8'h01;
      end
    end
  end

  // Option register
  always_ff @(posedge clk) begin
    if (srst) begin
      option_ff <= ebt_option_t'(EBT_RST_OPTION);
    end else if (wr_option) begin
      option_ff <= ebt_option_t'(wbyte);
    end
  end

  // Overflow flag: set wins over any software clear
  always_ff @(posedge clk) begin
    if (srst) begin
      overflow_flag_ff <= 1'b0;
    end else if (ce) begin
      if (rollover) begin
        overflow_flag_ff <= 1'b1;
      end else if (wr_intctl & ~wbyte[EBT_POS_OVF]) begin
        overflow_flag_ff <= 1'b0;
      end else if (wr_clear & avs_req.writedata[EBT_POS_EVT_OVF]) begin
        overflow_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      overflow_irq_enable_ff <= 1'b0;
    end else if (wr_intctl) begin
      overflow_irq_enable_ff <= wbyte[EBT_POS_IRQ_EN];
    end else if (wr_enable) begin
      overflow_irq_enable_ff <= avs_req.writedata[EBT_POS_EVT_OVF];
    end
  end

  assign irq = overflow_flag_ff & overflow_irq_enable_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      ovf_pulse_ff <= 1'b0;
    end else if (ce) begin
      ovf_pulse_ff <= rollover;
    end
  end
  assign overflow_pulse = ovf_pulse_ff;

  // Read mux; unmapped and write-only words read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (avs_req.address)
      {2'h0, EBT_OFF_OPTION}: nxt_rdata[7:0] = option_ff;
      {2'h0, EBT_OFF_INTCTL}: begin
        nxt_rdata[EBT_POS_IRQ_EN] = overflow_irq_enable_ff;
        nxt_rdata[EBT_POS_OVF]    = overflow_flag_ff;
      end
      {2'h0, EBT_OFF_COUNT}:  nxt_rdata[7:0] = count_ff;
      {2'h0, EBT_OFF_STATUS}: nxt_rdata[EBT_POS_EVT_OVF] = overflow_flag_ff;
      EBT_ADDR_ENABLE: nxt_rdata[EBT_POS_EVT_OVF] = overflow_irq_enable_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_state_ff <= EBT_RD_IDLE;
      rdata_ff    <= 32'h0000_0000;
    end else if (ce) begin
      unique case (rd_state_ff)
        EBT_RD_IDLE: begin
          if (rd_take) begin
            rdata_ff    <= nxt_rdata;
            rd_state_ff <= EBT_RD_DONE;
          end
        end
        EBT_RD_DONE: rd_state_ff <= EBT_RD_IDLE;
        default:     rd_state_ff <= EBT_RD_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* ebt_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_sva (
  // Clock and control
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  ce,
  // Bus side
  input wire ebt_pkg::ebt_avs_req_t avs_req,
  input wire logic                  avs_waitrequest,
  // Timer side
  input wire logic                  sleep_mode,
  input wire logic                  wdt_base_tick,
  input wire logic                  wdt_scaled_tick,
  input wire logic                  overflow_pulse,
  input wire logic                  irq
);
  import ebt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_wr; avs_req.write && ce |-> !avs_waitrequest; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_rd;
    $rose(avs_req.read) && ce |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_ce; !ce |-> avs_waitrequest; endproperty
  a_ce: assert property (p_ce) else $error("answer when frozen");
  property p_ovf; overflow_pulse |=> !overflow_pulse; endproperty
  a_ovf: assert property (p_ovf) else $error("wrap pulse long");
  property p_hold; $fell(irq) |-> $past(avs_req.write); endproperty
  a_hold: assert property (p_hold) else $error("irq dropped");
  // Enable and interrupt-control writes raise irq at once; any other rise needs a wrap
  property p_rise;
    $rose(irq) && !$past(avs_req.write) |-> overflow_pulse;
  endproperty
  a_rise: assert property (p_rise) else $error("irq no wrap");
  property p_sleep; sleep_mode |-> ##1 !overflow_pulse; endproperty
  a_sleep: assert property (p_sleep) else $error("wrap asleep");
  property p_wdt; wdt_scaled_tick |-> $past(wdt_base_tick); endproperty
  a_wdt: assert property (p_wdt) else $error("stray tick");
endmodule
bind ebt_timer ebt_timer_sva u_ebt_timer_sva (.clk(clk), .srst(srst),
  .ce(ce), .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
  .sleep_mode(sleep_mode), .wdt_base_tick(wdt_base_tick),
  .wdt_scaled_tick(wdt_scaled_tick), .overflow_pulse(overflow_pulse),
  .irq(irq));
`default_nettype wire

/* test_ebt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ebt_timer;
  import ebt_pkg::*;
  logic         clk, srst, ce, pin, slp, btk, wclr, wreq, stk, ovf, irq;
  ebt_avs_req_t req;
  logic [31:0]  rdata;
  logic [7:0]   q;
  int           bad_count, num_checks, nsc, n;
  ebt_timer u_ebt_timer (.clk(clk), .srst(srst), .ce(ce), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wreq),
    .external_count_pin(pin), .sleep_mode(slp), .wdt_base_tick(btk),
    .watchdog_clear_instruction(wclr), .wdt_scaled_tick(stk),
    .overflow_pulse(ovf), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (stk) nsc++;
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Waitrequest and read data are taken at the closing rising edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    int  k;
    logic wt;
    k = 0;
    @(posedge clk);
    req.address <= a;
    req.write <= w;
    req.read <= !w;
    req.writedata <= {24'h0, d};
    do begin
      @(posedge clk);
      wt = wreq;
      q = rdata[7:0];
      k++;
    end while (wt && k < 20);
    req.write <= 1'b0;
    req.read <= 1'b0;
    if (wt) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic wait_ovf;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!ovf && n < 5000);
    if (!ovf) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic rst(input int k);
    srst <= 1'b1;
    repeat (k) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      btk <= 1'b1;
      @(posedge clk);
      btk <= 1'b0;
    end
  endtask
  task automatic t_reset;
    rd(6'h00, EBT_RST_OPTION);
    rd(6'h08, 8'h00);
    rd(6'h04, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    chk(wreq, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
  endtask
  // Phase and inhibit slack allow a window around 8 clk per step
  task automatic t_rate;
    int r;
    for (int i = 0; i < 9; i++) begin
      r = (i < 8) ? (2 << i) : 1;
      wr(6'h00, (i < 8) ? 8'(i) : 8'h08);
      wr(6'h08, 8'hFE);
      wait_ovf();
      chk(8'(n >= 8 * r - 8 && n <= 8 * r + 20), 8'h01);
      rd(6'h08, 8'h00);
      chk(8'(q <= 8'h01), 8'h01);
    end
  endtask
  task automatic t_irq;
    rd(6'h0C, 8'h01);
    chk(irq, 1'b0);
    wr(6'h10, 8'h01);
    rd(6'h04, 8'h24);
    chk(irq, 1'b1);
    wr(6'h10, 8'h00);
    rd(6'h0C, 8'h01);
    chk(irq, 1'b0);
    wr(6'h14, 8'h01);
    rd(6'h0C, 8'h00);
    wr(6'h10, 8'h01);
    wait_ovf();
    wr(6'h04, 8'h24);
    chk(irq, 1'b1);
    wr(6'h04, 8'h20);
    rd(6'h04, 8'h20);
    rd(6'h18, 8'h00);
    wr(6'h10, 8'h00);
  endtask
  task automatic t_sleep;
    slp <= 1'b1;
    wr(6'h08, 8'h80);
    repeat (300) @(posedge clk);
    rd(6'h08, 8'h80);
    slp <= 1'b0;
  endtask
  task automatic t_count;
    for (int e = 0; e < 2; e++) begin
      wr(6'h00, 8'h28 | 8'(e << 4));
      wr(6'h08, 8'h00);
      repeat (16) @(posedge clk);
      pin <= 1'b1;
      repeat (16) @(posedge clk);
      rd(6'h08, 8'(1 - e));
      pin <= 1'b0;
      repeat (16) @(posedge clk);
      rd(6'h08, 8'h01);
    end
  endtask
  task automatic t_wdt;
    wr(6'h00, 8'h0A);
    nsc = 0;
    tick(8);
    repeat (4) @(posedge clk);
    chk(8'(nsc), 8'h02);
    nsc = 0;
    tick(3);
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    tick(3);
    repeat (4) @(posedge clk);
    chk(8'(nsc), 8'h00);
    wr(6'h00, 8'h02);
    nsc = 0;
    tick(3);
    repeat (4) @(posedge clk);
    chk(8'(nsc), 8'h03);
  endtask
  // A half-filled prescaler must restart on a count write
  task automatic t_presc;
    wr(6'h00, 8'h07);
    wr(6'h08, 8'hFF);
    repeat (600) @(posedge clk);
    wr(6'h08, 8'hFF);
    wait_ovf();
    chk(8'(n >= 1000 && n <= 1040), 8'h01);
    rd(6'h08, 8'h00);
  endtask
  initial begin
    {srst, ce, pin, slp, btk, wclr} = 6'b110000;
    req = '0;
    req.byteenable = 4'h1;
    bad_count = 0;
    num_checks = 0;
    nsc = 0;
    rst(20);
    t_reset();
    t_rate();
    t_irq();
    t_sleep();
    t_count();
    t_wdt();
    t_presc();
    rst(3);
    rd(6'h00, EBT_RST_OPTION);
    rd(6'h0C, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
